// ==== logic/sprc_ctl.sv ====
/*
  Sector protection table controller: decodes erase, program, read and status
  commands from the serial link, runs the self-timed table cycles, holds the
  eight-byte table and answers protection queries from the main array logic.
  Assumes a host that frames each command with select and a link clock no
  faster than a quarter of sys_clk; prot_enable and main_* are on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

`include "sprc_defs.svh"

module sprc_ctl
  import sprc_pkg::*;
#(
  parameter int ERASE_CYC = `SPRC_ERASE_CYC, // Erase cycle length in sys_clk cycles.
  parameter int PROG_CYC = `SPRC_PROG_CYC // Program cycle length in sys_clk cycles.
)(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe_n,
  input wire logic wp_n,
  input wire logic prot_enable,
  input wire logic [2:0] main_sector,
  input wire logic [6:0] main_page,
  output logic main_reject,
  output logic busy,
  output logic buf_wr_en,
  output logic [8:0] buf_wr_addr,
  output logic [7:0] buf_wr_data,
  output logic [63:0] sector_protect_map
);

  // The counter is sized for the longer of the two cycles.
  localparam int CW = $clog2((ERASE_CYC > PROG_CYC ? ERASE_CYC : PROG_CYC) + 1);

  // Zero-length cycles would wrap the counter and hold busy for a full wrap, so they are refused.
  if (ERASE_CYC < 1 || PROG_CYC < 1) begin : g_bad_cycles
    $error("sprc_ctl: cycle counts must be at least one");
  end

  // True when the table byte marks its sector, or sub-sector, protected.
  function automatic logic byte_protects(input logic [7:0] b, input logic [2:0] sec,
                                         input logic [6:0] page);
    if (sec != 3'h0) begin
      byte_protects = (b == `SPRC_BYTE_ERASED);
    end else if (page <= `SPRC_SEC0A_LAST_PAGE) begin
      byte_protects = &b[`SPRC_SEC0A_HI:`SPRC_SEC0A_LO];
    end else begin
      byte_protects = &b[`SPRC_SEC0B_HI:`SPRC_SEC0B_LO];
    end
  endfunction : byte_protects

  sprc_rx_s rx; // Frame events from the link.
  logic [7:0] tx_byte; // Next reply byte offered to the link.
  logic link_so; // Serial data from the link shifter.

  // Link logic runs on sys_clk and samples the pins through synchronisers.
  // The link must run below a quarter of sys_clk for the edges to be seen.
  sprc_link u_link (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sck(spi_sck),
    .cs_n(spi_cs_n),
    .si(spi_si),
    .tx_byte(tx_byte),
    .rx(rx),
    .so(link_so)
  );

  // The table lives in flip-flops and returns to all-open on reset, which
  // stands in for the delivered state; a real part would keep it across power.
  logic [1:0] wp_sync_ff, nxt_wp_sync; // Write-protect pin synchroniser.
  sprc_state_e state_ff, nxt_state; // Command sequencer state.
  logic [3:0] idx_ff, nxt_idx; // Table byte index for program and read.
  logic [1:0] dummy_ff, nxt_dummy; // Dummy byte count for a read.
  logic [7:0] tx_ff, nxt_tx; // Reply byte for the next byte slot.
  logic oe_ff, nxt_oe; // Serial output driven.
  logic [7:0] stage_ff [`SPRC_TABLE_BYTES]; // Program data held until the cycle.
  logic [7:0] nxt_stage [`SPRC_TABLE_BYTES];
  logic bwe_ff, nxt_bwe; // Buffer write strobe.
  logic [8:0] bwa_ff, nxt_bwa; // Buffer write address.
  logic [7:0] bwd_ff, nxt_bwd; // Buffer write data.
  logic start_erase, start_prog; // One-cycle cycle launches at frame end.
  logic busy_ff, nxt_busy; // Self-timed cycle running.
  logic is_erase_ff, nxt_is_erase; // Running cycle is an erase.
  logic [CW-1:0] cnt_ff, nxt_cnt; // Cycles left in the running cycle.
  logic [7:0] table_ff [`SPRC_TABLE_BYTES]; // The protection table itself.
  logic [7:0] nxt_table [`SPRC_TABLE_BYTES];
  logic wp_act; // Write protect asserted.
  logic [7:0] status_byte; // Status reply.

  // Write protect is active low on the pin and active high inside.
  assign wp_act = ~wp_sync_ff[1];
  assign status_byte = {~busy_ff, 6'h00, prot_enable};
  assign tx_byte = tx_ff;
  assign spi_so = link_so;
  assign spi_so_oe_n = ~oe_ff;
  assign busy = busy_ff;
  assign buf_wr_en = bwe_ff;
  assign buf_wr_addr = bwa_ff;
  assign buf_wr_data = bwd_ff;

  // The map output lists sector zero in the low byte.
  // Sectors one to seven use the whole byte; sector zero splits in pairs.
  genvar gi;
  generate
    for (gi = 0; gi < `SPRC_TABLE_BYTES; gi++) begin : g_map
      assign sector_protect_map[gi*8 +: 8] = table_ff[gi];
    end
  endgenerate

  // Erased table with protection on blocks every main write or erase.
  // It is combinational so the main array sees a change the edge it lands.
  always_comb begin
    main_reject = prot_enable & byte_protects(table_ff[main_sector], main_sector,
                                              main_page);
  end

  // A frame is decoded byte by byte; select rising always returns to idle,
  // so a cut frame never leaves a half-decoded command behind. Write protect
  // is sampled once, at the subcode byte; a pin change later in the frame
  // does not stop the cycle that the frame arms.
  // Command sequencer: decodes bytes and prepares replies.
  always_comb begin
    nxt_wp_sync = {wp_sync_ff[0], wp_n};
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_dummy = dummy_ff;
    nxt_tx = tx_ff;
    nxt_oe = oe_ff;
    nxt_stage = stage_ff;
    nxt_bwe = 1'b0;
    nxt_bwa = bwa_ff;
    nxt_bwd = bwd_ff;
    start_erase = 1'b0;
    start_prog = 1'b0;
    if (rx.stop) begin
      // Select high ends every command; an armed one launches its cycle.
      if (state_ff == SPRC_ARM_ERASE) begin
        start_erase = 1'b1;
      end
      if (state_ff == SPRC_PDATA) begin
        start_prog = 1'b1;
      end
      nxt_state = SPRC_IDLE;
      nxt_oe = 1'b0;
    end else if (rx.start) begin
      nxt_state = SPRC_OPC;
    end else if (rx.valid) begin
      unique case (state_ff)
        SPRC_IDLE: begin
          nxt_state = SPRC_IGNORE;
        end
        SPRC_OPC: begin
          if (rx.data == `SPRC_OPC_STATUS) begin
            // Status stays available during a cycle so the host can poll.
            nxt_state = SPRC_STAT;
            nxt_tx = status_byte;
            nxt_oe = 1'b1;
          end else if (busy_ff) begin
            nxt_state = SPRC_IGNORE;
          end else if (rx.data == `SPRC_OPC_PFX0) begin
            nxt_state = SPRC_PFX1;
          end else if (rx.data == `SPRC_OPC_READ) begin
            nxt_state = SPRC_RDUMMY;
            nxt_dummy = 2'h0;
          end else begin
            nxt_state = SPRC_IGNORE;
          end
        end
        SPRC_PFX1: begin
          nxt_state = (rx.data == `SPRC_OPC_PFX1) ? SPRC_PFX2 : SPRC_IGNORE;
        end
        SPRC_PFX2: begin
          nxt_state = (rx.data == `SPRC_OPC_PFX2) ? SPRC_SUB : SPRC_IGNORE;
        end
        SPRC_SUB: begin
          // prot_enable is not consulted here at all.
          if (wp_act) begin
            nxt_state = SPRC_IGNORE;
          end else if (rx.data == `SPRC_OPC_ERASE) begin
            nxt_state = SPRC_ARM_ERASE;
          end else if (rx.data == `SPRC_OPC_PROG) begin
            nxt_state = SPRC_PDATA;
            nxt_idx = 4'h0;
          end else begin
            nxt_state = SPRC_IGNORE;
          end
        end
        SPRC_ARM_ERASE: begin
          // Extra bytes after the erase opcode are not an error here.
          nxt_state = SPRC_ARM_ERASE;
        end
        SPRC_PDATA: begin
          // Each byte goes to the buffer and the staging copy, sector order.
          nxt_stage[idx_ff[2:0]] = rx.data;
          nxt_bwe = 1'b1;
          nxt_bwa = {6'h00, idx_ff[2:0]};
          nxt_bwd = rx.data;
          nxt_idx = {1'b0, idx_ff[2:0] + 3'h1};
        end
        SPRC_RDUMMY: begin
          nxt_dummy = dummy_ff + 2'h1;
          if (dummy_ff == `SPRC_DUMMY_LAST) begin
            nxt_state = SPRC_RDATA;
            nxt_idx = 4'h0;
            nxt_tx = table_ff[0];
            nxt_oe = 1'b1;
          end
        end
        SPRC_RDATA: begin
          // The index stops at eight; past it the reply is filler.
          if (idx_ff < 4'(`SPRC_TABLE_BYTES)) begin
            nxt_idx = idx_ff + 4'h1;
          end
          if (idx_ff < 4'(`SPRC_TABLE_BYTES - 1)) begin
            nxt_tx = table_ff[idx_ff[2:0] + 3'h1];
          end else begin
            nxt_tx = `SPRC_UNDEF_BYTE;
          end
        end
        SPRC_STAT: begin
          nxt_tx = status_byte;
        end
        SPRC_IGNORE: begin
          nxt_state = SPRC_IGNORE;
        end
      endcase
    end
  end

  // The staging copy keeps the last program data, so bytes a short frame
  // did not send reuse old values, which is why the host sends all eight.
  // Registers of the sequencer.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wp_sync_ff <= 2'h3;
      state_ff <= SPRC_IDLE;
      idx_ff <= 4'h0;
      dummy_ff <= 2'h0;
      tx_ff <= 8'h00;
      oe_ff <= 1'b0;
      for (int i = 0; i < `SPRC_TABLE_BYTES; i++) begin
        stage_ff[i] <= 8'h00;
      end
      bwe_ff <= 1'b0;
      bwa_ff <= 9'h000;
      bwd_ff <= 8'h00;
    end else begin
      wp_sync_ff <= nxt_wp_sync;
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      dummy_ff <= nxt_dummy;
      tx_ff <= nxt_tx;
      oe_ff <= nxt_oe;
      stage_ff <= nxt_stage;
      bwe_ff <= nxt_bwe;
      bwa_ff <= nxt_bwa;
      bwd_ff <= nxt_bwd;
    end
  end

  // A reset during a cycle abandons it and the table shows the reset value;
  // the host must then repeat the erase or program.
  // Self-timed cycle: counts down and updates the table at the end.
  always_comb begin
    nxt_busy = busy_ff;
    nxt_is_erase = is_erase_ff;
    nxt_cnt = cnt_ff;
    nxt_table = table_ff;
    if (start_erase) begin
      nxt_busy = 1'b1;
      nxt_is_erase = 1'b1;
      nxt_cnt = CW'(ERASE_CYC);
    end else if (start_prog) begin
      nxt_busy = 1'b1;
      nxt_is_erase = 1'b0;
      nxt_cnt = CW'(PROG_CYC);
    end else if (busy_ff) begin
      nxt_cnt = cnt_ff - CW'(1);
      if (cnt_ff == CW'(1)) begin
        nxt_busy = 1'b0;
        for (int i = 0; i < `SPRC_TABLE_BYTES; i++) begin
          // The new values appear in the same edge that busy drops.
          nxt_table[i] = is_erase_ff ? `SPRC_BYTE_ERASED : stage_ff[i];
        end
      end
    end
  end

  // Registers of the cycle timer and the table.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      is_erase_ff <= 1'b0;
      cnt_ff <= '0;
      for (int i = 0; i < `SPRC_TABLE_BYTES; i++) begin
        table_ff[i] <= 8'(`SPRC_MAP_RESET >> (i * 8));
      end
    end else begin
      busy_ff <= nxt_busy;
      is_erase_ff <= nxt_is_erase;
      cnt_ff <= nxt_cnt;
      table_ff <= nxt_table;
    end
  end

endmodule : sprc_ctl

`default_nettype wire

// ==== logic/sprc_defs.svh ====
/*
  Constants of the sector protection table controller: opcodes, byte values,
  field positions, table size and self-timed cycle lengths.
  Assumes it is included by bare name wherever these names are used.
*/
`ifndef SPRC_DEFS_SVH
`define SPRC_DEFS_SVH

`define SPRC_OPC_PFX0 8'h3D
`define SPRC_OPC_PFX1 8'h2A
`define SPRC_OPC_PFX2 8'h7F
`define SPRC_OPC_ERASE 8'hCF
`define SPRC_OPC_PROG 8'hFC
`define SPRC_OPC_READ 8'h32
`define SPRC_OPC_STATUS 8'hD7
`define SPRC_BYTE_ERASED 8'hFF
`define SPRC_UNDEF_BYTE 8'hFF
`define SPRC_MAP_RESET 64'h0000000000000000
`define SPRC_TABLE_BYTES 8
`define SPRC_DUMMY_LAST 2'h2
`define SPRC_SEC0A_HI 7
`define SPRC_SEC0A_LO 6
`define SPRC_SEC0B_HI 5
`define SPRC_SEC0B_LO 4
`define SPRC_SEC0A_LAST_PAGE 7'h07
`define SPRC_STAT_READY_BIT 7
`define SPRC_STAT_PROT_BIT 0
`define SPRC_CLK_MHZ 25
`define SPRC_T_ERASE_US 4000
`define SPRC_T_PROG_US 3000
`define SPRC_ERASE_CYC (`SPRC_T_ERASE_US * `SPRC_CLK_MHZ)
`define SPRC_PROG_CYC (`SPRC_T_PROG_US * `SPRC_CLK_MHZ)

`endif

// ==== logic/sprc_link.sv ====
/*
  Serial link of the protection table controller: synchronises the pins,
  finds clock edges, assembles received bytes and shifts out reply bytes.
  Assumes mode 0 framing and a link clock well below a quarter of sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module sprc_link
  import sprc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic [7:0] tx_byte,
  output sprc_rx_s rx,
  output logic so
);

  logic [1:0] sck_sync_ff, nxt_sck_sync; // Two-stage synchroniser for the clock.
  logic [1:0] cs_sync_ff, nxt_cs_sync; // Two-stage synchroniser for select.
  logic [1:0] si_sync_ff, nxt_si_sync; // Two-stage synchroniser for data in.
  logic sck_d_ff, nxt_sck_d; // Last synchronised clock, for edge finding.
  logic cs_d_ff, nxt_cs_d; // Last synchronised select, for edge finding.
  logic [2:0] bit_ff, nxt_bit; // Bit position within the current byte.
  logic [7:0] sr_ff, nxt_sr; // Receive shift register.
  logic [7:0] tx_ff, nxt_tx; // Transmit shift register.
  sprc_rx_s rx_ff, nxt_rx; // Registered frame events.
  logic sck_rise, sck_fall, cs_act;

  // Only the second synchroniser stage and the delayed copy feed logic.
  assign sck_rise = sck_sync_ff[1] & ~sck_d_ff;
  assign sck_fall = ~sck_sync_ff[1] & sck_d_ff;
  assign cs_act = ~cs_sync_ff[1];
  assign rx = rx_ff;
  assign so = tx_ff[7];

  // Next-state logic for synchronisers, shifter and events.
  always_comb begin
    nxt_sck_sync = {sck_sync_ff[0], sck};
    nxt_cs_sync = {cs_sync_ff[0], cs_n};
    nxt_si_sync = {si_sync_ff[0], si};
    nxt_sck_d = sck_sync_ff[1];
    nxt_cs_d = cs_sync_ff[1];
    nxt_bit = bit_ff;
    nxt_sr = sr_ff;
    nxt_tx = tx_ff;
    nxt_rx = '0;
    nxt_rx.data = rx_ff.data;
    nxt_rx.start = cs_act & cs_d_ff;
    nxt_rx.stop = ~cs_act & ~cs_d_ff;
    if (!cs_act) begin
      // Outside a frame the bit counter rests at the byte boundary.
      nxt_bit = 3'h0;
    end else if (sck_rise) begin
      nxt_sr = {sr_ff[6:0], si_sync_ff[1]};
      nxt_bit = bit_ff + 3'h1;
      if (bit_ff == 3'h7) begin
        nxt_rx.valid = 1'b1;
        nxt_rx.data = {sr_ff[6:0], si_sync_ff[1]};
      end
    end else if (sck_fall) begin
      // A fall at the boundary loads the next reply byte, else shift.
      nxt_tx = (bit_ff == 3'h0) ? tx_byte : {tx_ff[6:0], 1'b0};
    end
  end

  // Registers of the link.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sck_sync_ff <= 2'h0;
      cs_sync_ff <= 2'h3;
      si_sync_ff <= 2'h0;
      sck_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
      bit_ff <= 3'h0;
      sr_ff <= 8'h00;
      tx_ff <= 8'h00;
      rx_ff <= '0;
    end else begin
      sck_sync_ff <= nxt_sck_sync;
      cs_sync_ff <= nxt_cs_sync;
      si_sync_ff <= nxt_si_sync;
      sck_d_ff <= nxt_sck_d;
      cs_d_ff <= nxt_cs_d;
      bit_ff <= nxt_bit;
      sr_ff <= nxt_sr;
      tx_ff <= nxt_tx;
      rx_ff <= nxt_rx;
    end
  end

endmodule : sprc_link

`default_nettype wire

// ==== logic/sprc_pkg.sv ====
/*
  Types shared by the sector protection table controller and its link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sprc_pkg;

  // Command sequencer states.
  typedef enum logic [3:0] {
    SPRC_IDLE = 4'h0,
    SPRC_OPC = 4'h1,
    SPRC_PFX1 = 4'h2,
    SPRC_PFX2 = 4'h3,
    SPRC_SUB = 4'h4,
    SPRC_ARM_ERASE = 4'h5,
    SPRC_PDATA = 4'h6,
    SPRC_RDUMMY = 4'h7,
    SPRC_RDATA = 4'h8,
    SPRC_STAT = 4'h9,
    SPRC_IGNORE = 4'hA
  } sprc_state_e;

  // Events of one frame as seen from the system clock.
  typedef struct packed {
    logic start;
    logic stop;
    logic valid;
    logic [7:0] data;
  } sprc_rx_s;

endpackage : sprc_pkg

// ==== verif/sector_protect_register_ctl_tb_top.sv ====
/* Testbench of the protection table controller with a host model.
   Assumes shortened self-timed cycles so the run stays brief. */
`timescale 1ns/1ps
`default_nettype none
`include "sprc_defs.svh"
module sector_protect_register_ctl_tb_top;
  localparam int ERASE_N = 600; // Shortened erase, distinct from program.
  localparam int PROG_N = 500;
  logic sys_clk, rst_n, wp_n, prot_enable, sck, cs_n, si, so, so_oe_n;
  logic main_reject, busy, buf_wr_en;
  logic [2:0] main_sector;
  logic [6:0] main_page;
  logic [8:0] buf_wr_addr;
  logic [7:0] buf_wr_data, rx, b;
  logic [63:0] map;
  logic [7:0] exp_map [8]; // Expected table contents.
  logic [7:0] wr_q [16]; // Bytes sent in the current program frame.
  int mismatches, n_checks, nwr, blen, last_len;
  bit oe_seen;
  sprc_ctl #(.ERASE_CYC(ERASE_N), .PROG_CYC(PROG_N)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .spi_sck(sck), .spi_cs_n(cs_n), .spi_si(si), .spi_so(so), .spi_so_oe_n(so_oe_n),
    .wp_n(wp_n), .prot_enable(prot_enable), .main_sector(main_sector),
    .main_page(main_page), .main_reject(main_reject), .busy(busy), .buf_wr_en(buf_wr_en),
    .buf_wr_addr(buf_wr_addr), .buf_wr_data(buf_wr_data), .sector_protect_map(map));
  sprc_host host (.sys_clk(sys_clk), .so(so), .sck(sck), .cs_n(cs_n), .si(si));
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  function automatic logic [63:0] packed_exp();
    for (int i = 0; i < 8; i++)
      packed_exp[i*8 +: 8] = exp_map[i];
  endfunction : packed_exp
  // Watches buffer writes, output enable and how long busy stands.
  always @(posedge sys_clk) begin
    if (buf_wr_en === 1'b1) begin
      check("buf_addr", {55'h0, buf_wr_addr}, 64'(nwr % 8));
      check("buf_data", {56'h0, buf_wr_data}, {56'h0, wr_q[nwr]});
      nwr++;
    end
    if (so_oe_n === 1'b0)
      oe_seen = 1'b1;
    if (busy === 1'b1)
      blen++;
    else if (blen != 0) begin
      last_len = blen;
      blen = 0;
    end
  end
  task automatic cmd4(input logic [7:0] sub);
    host.begin_frame();
    foreach (wr_q[i]) // Prefix bytes; the queue only sets the loop count here.
      if (i < 3)
        host.xfer(i == 0 ? `SPRC_OPC_PFX0 : (i == 1 ? `SPRC_OPC_PFX1 : `SPRC_OPC_PFX2), rx);
    host.xfer(sub, rx);
  endtask : cmd4
  // Waits for a started cycle to finish; a refused one never raises busy.
  task automatic wait_idle();
    for (int i = 0; i < 20 && busy !== 1'b1; i++) host.cyc(1);
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) host.cyc(1);
    host.cyc(2);
  endtask : wait_idle
  task automatic read_table();
    host.begin_frame();
    host.xfer(`SPRC_OPC_READ, rx);
    repeat (3) host.xfer(8'($urandom), rx);
    for (int k = 0; k < 9; k++) begin
      host.xfer(8'($urandom), rx);
      check("read_byte", {56'h0, rx}, {56'h0, k < 8 ? exp_map[k] : `SPRC_UNDEF_BYTE});
    end
    host.end_frame();
    check("oe_released", {63'h0, so_oe_n}, 64'h1);
  endtask : read_table
  // Status polls stay answered while busy; bit 7 is ready, bit 0 protection.
  task automatic status_check(input logic bz);
    host.begin_frame();
    host.xfer(`SPRC_OPC_STATUS, rx);
    repeat (2) begin
      host.xfer(8'($urandom), rx);
      check("status", {56'h0, rx}, {56'h0, ~bz, 6'h00, prot_enable});
    end
    host.end_frame();
  endtask : status_check
  // Queries the main array side, pages 6 to 9 first to cross the subsector edge.
  task automatic query_check();
    logic [1:0] pr;
    for (int q = 0; q < 16; q++) begin
      prot_enable <= q[0];
      main_sector <= (q < 4) ? 3'h0 : 3'($urandom_range(7));
      main_page <= (q < 4) ? 7'(q + 6) : 7'($urandom_range(127));
      host.cyc(1);
      b = exp_map[main_sector];
      pr = (main_sector != 3'h0) ? {b[7], b[0]} : ((main_page <= 7'h07) ? b[7:6] : b[5:4]);
      check("reject", {63'h0, main_reject}, {63'h0, q[0] && pr == 2'b11});
    end
  endtask : query_check
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    host.cyc(40000);
    mismatches++;
    close_out();
  end
  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    prot_enable = 1'b0;
    main_sector = 3'h0;
    main_page = 7'h00;
    void'($urandom(48));
    foreach (exp_map[i]) exp_map[i] = 8'(`SPRC_MAP_RESET >> (i * 8));
    host.cyc(16);
    rst_n <= 1'b1;
    host.cyc(6);
    check("map_reset", map, `SPRC_MAP_RESET);
    read_table();
    for (int r = 0; r < 3; r++) begin
      prot_enable <= (r == 2) ? 1'($urandom_range(1)) : r[0];
      cmd4(`SPRC_OPC_ERASE);
      host.end_frame();
      oe_seen = 1'b0; // A read frame of opcode and five bytes sent while busy must stay silent.
      host.begin_frame();
      host.xfer(`SPRC_OPC_READ, rx);
      repeat (5) host.xfer(8'($urandom), rx);
      host.end_frame();
      check("busy_ignored", {63'h0, oe_seen}, 64'h0);
      status_check(1'b1);
      wait_idle();
      check("erase_len", 64'(last_len), 64'(ERASE_N));
      status_check(1'b0);
      foreach (exp_map[i]) exp_map[i] = `SPRC_BYTE_ERASED;
      check("map_erased", map, packed_exp());
      query_check();
      prot_enable <= r[0];
      nwr = 0;
      cmd4(`SPRC_OPC_PROG);
      // Whole table each time, erased first, few rewrites.
      for (int k = 0; k < 8 + r; k++) begin
        b = 8'($urandom);
        // Sector zero takes pair codes with a random don't-care nibble.
        b = (k % 8 == 0) ? {{2{b[7]}}, {2{b[5]}}, b[3:0]} : (b[0] ? 8'hFF : 8'h00);
        wr_q[k] = b;
        exp_map[k % 8] = b;
        host.xfer(b, rx);
      end
      host.end_frame();
      wait_idle();
      check("prog_len", 64'(last_len), 64'(PROG_N));
      check("buf_writes", 64'(nwr), 64'(8 + r));
      check("map_prog", map, packed_exp());
      read_table();
      query_check();
    end
    wp_n <= 1'b0;
    last_len = 0;
    cmd4(`SPRC_OPC_ERASE);
    host.end_frame();
    cmd4(`SPRC_OPC_PROG);
    host.end_frame();
    wait_idle();
    check("wp_no_cycle", 64'(last_len), 64'h0);
    check("wp_map", map, packed_exp());
    // Released write protect lets an erase start; a reset then aborts it.
    wp_n <= 1'b1;
    cmd4(`SPRC_OPC_ERASE);
    host.end_frame();
    check("wp_off_busy", {63'h0, busy}, 64'h1);
    rst_n <= 1'b0;
    host.cyc(4);
    rst_n <= 1'b1;
    host.cyc(6);
    check("busy_reset", {63'h0, busy}, 64'h0);
    check("map_rereset", map, `SPRC_MAP_RESET);
    foreach (exp_map[i]) exp_map[i] = 8'(`SPRC_MAP_RESET >> (i * 8));
    read_table();
    close_out();
  end
endmodule : sector_protect_register_ctl_tb_top
bind sprc_ctl sprc_ctl_chk #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC)) u_chk (.sys_clk,
  .rst_n, .spi_cs_n, .spi_so_oe_n, .wp_n, .prot_enable, .main_sector, .main_page,
  .main_reject, .busy, .buf_wr_en, .buf_wr_addr, .sector_protect_map);
`default_nettype wire

// ==== verif/sprc_ctl_chk.sv ====
/* Checker of the protection table controller, bound to its top ports.
   Assumes one clock, sys_clk, and the synchronous active-low rst_n. */
`timescale 1ns/1ps
`default_nettype none
module sprc_ctl_chk #(
  parameter int ERASE_CYC = 20,
  parameter int PROG_CYC = 15
)(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic spi_cs_n,
  input wire logic spi_so_oe_n,
  input wire logic wp_n,
  input wire logic prot_enable,
  input wire logic [2:0] main_sector,
  input wire logic [6:0] main_page,
  input wire logic main_reject,
  input wire logic busy,
  input wire logic buf_wr_en,
  input wire logic [8:0] buf_wr_addr,
  input wire logic [63:0] sector_protect_map
);
  localparam int BMAX = (ERASE_CYC > PROG_CYC) ? ERASE_CYC : PROG_CYC;
  int bcnt_ff; // Cycles busy has stood so far.
  int nxt_bcnt;
  logic [7:0] wlo_ff; // Cycles write protect has been held low, saturating.
  logic [7:0] nxt_wlo;
  logic [1:0] pr; // 11 protect, 00 open, other values are undefined codes.
  // Sectors 1 to 7 use the whole byte, sector 0 splits by page.
  function automatic logic [1:0] pair_of(logic [63:0] m, logic [2:0] s, logic [6:0] p);
    logic [7:0] b;
    b = m[s*8 +: 8];
    if (s != 3'h0)
      return {b == 8'hFF, b != 8'h00};
    return (p <= 7'h07) ? b[7:6] : b[5:4];
  endfunction : pair_of
  assign pr = pair_of(sector_protect_map, main_sector, main_page);
  // Next values of the helper counters.
  always_comb begin
    nxt_bcnt = busy ? bcnt_ff + 1 : 0;
    nxt_wlo = wp_n ? 8'h00 : ((wlo_ff == 8'hFF) ? wlo_ff : wlo_ff + 8'h01);
  end
  // Helper counters only register here.
  always_ff @(posedge sys_clk) begin
    bcnt_ff <= rst_n ? nxt_bcnt : 0;
    wlo_ff <= rst_n ? nxt_wlo : 8'h00;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence seq_sel_idle;
    spi_cs_n [*8];
  endsequence
  sequence seq_wr_pulse;
    buf_wr_en ##1 !buf_wr_en;
  endsequence
  AST_BUSY_LEN: assert property ($fell(busy) |-> (bcnt_ff == ERASE_CYC || bcnt_ff == PROG_CYC))
    else $error("busy stood for a wrong number of cycles");
  AST_BUSY_BOUND: assert property (busy |-> bcnt_ff < BMAX)
    else $error("busy stands too long");
  AST_BUSY_AFTER_SEL: assert property ($rose(busy) |-> spi_cs_n && $past(spi_cs_n, 4))
    else $error("self-timed cycle started with select low");
  AST_MAP_STEADY: assert property ($changed(sector_protect_map) |-> $fell(busy))
    else $error("table changed outside the end of a cycle");
  AST_ERASE_ALL_FF: assert property ($fell(busy) && bcnt_ff == ERASE_CYC |-> sector_protect_map == {8{8'hFF}})
    else $error("erase did not leave every byte FF");
  AST_REJECT: assert property (pr == 2'b11 || pr == 2'b00 |-> main_reject == (prot_enable && pr == 2'b11))
    else $error("main reject disagrees with the table");
  AST_OE_SELECT: assert property (seq_sel_idle |-> spi_so_oe_n)
    else $error("serial output driven without select");
  AST_BUF_PULSE: assert property (buf_wr_en |-> seq_wr_pulse)
    else $error("buffer write longer than one cycle");
  AST_BUF_ADDR: assert property (buf_wr_en |-> buf_wr_addr < 9'h008 && !busy)
    else $error("buffer write outside the table range");
  AST_WP_HOLDS: assert property ($rose(busy) |-> wlo_ff < 8'd200)
    else $error("table cycle started under write protect");
endmodule : sprc_ctl_chk
`default_nettype wire

// ==== verif/sprc_host.sv ====
/* Host model: frames commands on the serial link in mode 0.
   Assumes a 40 ns sys_clk; the link clock period is 8 sys_clk cycles. */
`timescale 1ns/1ps
`default_nettype none
module sprc_host (
  input wire logic sys_clk,
  input wire logic so,
  output logic sck,
  output logic cs_n,
  output logic si
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // Outside frames the data line toggles so no stale bit looks valid.
  always @(posedge sys_clk) begin
    if (cs_n)
      si <= ~si;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  // Select falls a full link period before the first rise.
  task automatic begin_frame();
    cyc(1);
    cs_n <= 1'b0;
    cyc(4);
  endtask : begin_frame
  // Data changes while the clock is low and is read mid-high, MSB first.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck <= 1'b0;
      si <= tx[i];
      cyc(4);
      sck <= 1'b1;
      cyc(2);
      rx[i] = so;
      cyc(2);
    end
  endtask : xfer
  // The link clock stands low between frames.
  task automatic end_frame();
    sck <= 1'b0;
    cyc(4);
    cs_n <= 1'b1;
    cyc(8);
  endtask : end_frame
endmodule : sprc_host
`default_nettype wire
